// ---- design/ets_defs.svh ----
`ifndef ETS_DEFS_SVH
`define ETS_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ETS_OFF_S5_NS 12'h584
`define ETS_OFF_S5_SEC 12'h588
`define ETS_OFF_S5_PH 12'h58c
`define ETS_OFF_S6_NS 12'h590
`define ETS_OFF_S6_SEC 12'h594
`define ETS_OFF_S6_PH 12'h598
`define ETS_OFF_UNIT_IDX 12'h5e0
`define ETS_OFF_CTRL 12'h5e4
`define ETS_OFF_INT_STAT 12'h5e8
`define ETS_OFF_INT_MASK 12'h5ec

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ETS_IDX_PTR_BIT 8
`define ETS_NS_POL_BIT 30
`define ETS_CTRL_RISE_LSB 0
`define ETS_CTRL_FALL_LSB 2
`define ETS_CTRL_REARM_LSB 8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ETS_CTRL_EN_RST 4'hf
`define ETS_INT_MASK_RST 4'h0

// ----------------------------------------------------------------------
// sub-slot phase codes (16 ns slot moved off the reserved range)
// ----------------------------------------------------------------------
`define ETS_PH_0NS 3'h0
`define ETS_PH_8NS 3'h1
`define ETS_PH_16NS 3'h2
`define ETS_PH_24NS 3'h3
`define ETS_PH_32NS 3'h4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ETS_CLK_PERIOD_NS 5
`define ETS_REF_PERIOD_NS 40
`define ETS_SLOT_NS 8
`define ETS_REF_CYCLES (`ETS_REF_PERIOD_NS / `ETS_CLK_PERIOD_NS)
`define ETS_NS_PER_SEC 30'h3b9aca00

`endif

// ---- design/ets_pkg.sv ----
package ets_pkg;

    // one captured sample
    typedef struct packed {
        logic pol;
        logic [29:0] ns;
        logic [31:0] sec;
        logic [2:0] phase;
    } ets_sample_t;

    // running time of day
    typedef struct packed {
        logic [29:0] ns;
        logic [31:0] sec;
        logic [2:0] phase;
    } ets_time_t;

    // register bus request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ets_bus_req_t;

endpackage

// ---- design/ets_edge_sync.sv ----
`timescale 1ns/1ps

module ets_edge_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // event pin
    input wire logic pin,
    // edge pulses
    output logic rise,
    output logic fall
);
    logic sync1_ff;
    logic sync2_ff;
    logic last_ff;

    // two-stage synchroniser, then edge detect on stage two
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            last_ff <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
            last_ff <= sync2_ff;
            rise <= sync2_ff & ~last_ff;
            fall <= ~sync2_ff & last_ff;
        end
    end
endmodule // ets_edge_sync

// ---- design/ets_sample_slot.sv ----
`timescale 1ns/1ps

module ets_sample_slot (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // capture request
    input wire logic cap,
    input wire logic pol,
    input wire ets_pkg::ets_time_t now,
    // stored sample
    output ets_pkg::ets_sample_t q
);
    import ets_pkg::*;

    // latch time and polarity on capture, hold otherwise
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else if (cap) begin
            q <= {pol, now.ns, now.sec, now.phase};
        end
    end
endmodule // ets_sample_slot

// ---- design/ets_capture_top.sv ----
`timescale 1ns/1ps
`include "ets_defs.svh"


module ets_capture_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire ets_pkg::ets_bus_req_t bus,
    output logic [31:0] rdata,
    // event pins, one per unit
    input wire logic [1:0] ts_in,
    // interrupt
    output logic irq
);
    import ets_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [2:0] sub_cnt_ff;
    logic [29:0] ns_ff;
    logic [31:0] sec_ff;
    logic [5:0] elapsed_ns;
    logic [2:0] slot_idx;
    logic [2:0] phase_code;
    ets_time_t now;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] ev;
    logic idx_ff;
    logic [1:0] rise_en_ff;
    logic [1:0] fall_en_ff;
    logic [1:0] rearm;
    logic [2:0] cnt_ff [2];
    logic [3:0] cap;
    ets_sample_t slot_q [4];
    logic [3:0] int_stat_ff;
    logic [3:0] int_mask_ff;
    logic [31:0] nxt_rdata;
    logic unit_sel;
    ets_sample_t sel5;
    ets_sample_t sel6;
    // edge enables come out of reset all on
    localparam logic [3:0] CTRL_EN_RST = `ETS_CTRL_EN_RST;

    assign unit_sel = idx_ff;

    // ------------------------------------------------------------------
    // local time of day on the 25 MHz grid
    // ------------------------------------------------------------------

    // sub-cycle counter inside one 40 ns period
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_cnt_ff <= 3'h0;
        end else if (sub_cnt_ff == 3'(`ETS_REF_CYCLES - 1)) begin
            sub_cnt_ff <= 3'h0;
        end else begin
            sub_cnt_ff <= sub_cnt_ff + 3'h1;
        end
    end

    // nanoseconds advance 40 per period, carry into seconds
    always_ff @(posedge clk) begin
        if (rst) begin
            ns_ff <= 30'h0;
            sec_ff <= 32'h0;
        end else if (sub_cnt_ff == 3'(`ETS_REF_CYCLES - 1)) begin
            if (ns_ff >= `ETS_NS_PER_SEC - 30'(`ETS_REF_PERIOD_NS)) begin
                ns_ff <= 30'h0;
                sec_ff <= sec_ff + 32'h1;
            end else begin
                ns_ff <= ns_ff + 30'(`ETS_REF_PERIOD_NS);
            end
        end
    end

    // map elapsed time in the period onto one of five 8 ns slots
    assign elapsed_ns = 6'(sub_cnt_ff) * 6'(`ETS_CLK_PERIOD_NS);
    assign slot_idx = 3'(elapsed_ns / 6'(`ETS_SLOT_NS));

    always_comb begin
        unique case (slot_idx)
            3'h0: phase_code = `ETS_PH_0NS;
            3'h1: phase_code = `ETS_PH_8NS;
            3'h2: phase_code = `ETS_PH_16NS;
            3'h3: phase_code = `ETS_PH_24NS;
            3'h4: phase_code = `ETS_PH_32NS;
            default: phase_code = `ETS_PH_0NS;
        endcase
    end

    assign now = '{ns: ns_ff, sec: sec_ff, phase: phase_code};

    // ------------------------------------------------------------------
    // event detection and sample ordering
    // ------------------------------------------------------------------
    for (genvar u = 0; u < 2; u++) begin : g_unit
        ets_edge_sync u_sync (
            .clk(clk),
            .rst(rst),
            .pin(ts_in[u]),
            .rise(rise[u]),
            .fall(fall[u])
        );

        assign ev[u] = (rise[u] & rise_en_ff[u]) | (fall[u] & fall_en_ff[u]);
        // fifth and sixth qualified edges land in this block
        assign cap[2*u] = ev[u] && (cnt_ff[u] == 3'h4);
        assign cap[2*u+1] = ev[u] && (cnt_ff[u] == 3'h5);

        // edge count, saturating once the sixth has landed
        always_ff @(posedge clk) begin
            if (rst) begin
                cnt_ff[u] <= 3'h0;
            end else if (rearm[u]) begin
                cnt_ff[u] <= {2'h0, ev[u]};
            end else if (ev[u] && cnt_ff[u] != 3'h6) begin
                cnt_ff[u] <= cnt_ff[u] + 3'h1;
            end
        end

        for (genvar s = 0; s < 2; s++) begin : g_slot
            ets_sample_slot u_slot (
                .clk(clk),
                .rst(rst),
                .cap(cap[2*u+s]),
                .pol(rise[u]),
                .now(now),
                .q(slot_q[2*u+s])
            );
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------

    // unit index and control; rearm bits act once and are not stored
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_ff <= 1'b0;
            rise_en_ff <= CTRL_EN_RST[`ETS_CTRL_RISE_LSB +: 2];
            fall_en_ff <= CTRL_EN_RST[`ETS_CTRL_FALL_LSB +: 2];
        end else if (bus.wr && bus.addr == `ETS_OFF_UNIT_IDX) begin
            idx_ff <= bus.wdata[`ETS_IDX_PTR_BIT];
        end else if (bus.wr && bus.addr == `ETS_OFF_CTRL) begin
            rise_en_ff <= bus.wdata[`ETS_CTRL_RISE_LSB +: 2];
            fall_en_ff <= bus.wdata[`ETS_CTRL_FALL_LSB +: 2];
        end
    end

    assign rearm = (bus.wr && bus.addr == `ETS_OFF_CTRL) ?
        bus.wdata[`ETS_CTRL_REARM_LSB +: 2] : 2'h0;

    // sticky capture flags, write one to clear, a new capture wins
    always_ff @(posedge clk) begin
        if (rst) begin
            int_stat_ff <= 4'h0;
        end else if (bus.wr && bus.addr == `ETS_OFF_INT_STAT) begin
            int_stat_ff <= (int_stat_ff & ~bus.wdata[3:0]) | cap;
        end else begin
            int_stat_ff <= int_stat_ff | cap;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            int_mask_ff <= `ETS_INT_MASK_RST;
        end else if (bus.wr && bus.addr == `ETS_OFF_INT_MASK) begin
            int_mask_ff <= bus.wdata[3:0];
        end
    end

    assign irq = |(int_stat_ff & int_mask_ff);

    // ------------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ------------------------------------------------------------------
    assign sel5 = slot_q[{unit_sel, 1'b0}];
    assign sel6 = slot_q[{unit_sel, 1'b1}];

    // sample registers are read only and reserved bits are zero
    always_comb begin
        unique case (bus.addr)
            `ETS_OFF_S5_NS: nxt_rdata = {1'b0, sel5.pol, sel5.ns};
            `ETS_OFF_S5_SEC: nxt_rdata = sel5.sec;
            `ETS_OFF_S5_PH: nxt_rdata = {29'h0, sel5.phase};
            `ETS_OFF_S6_NS: nxt_rdata = {1'b0, sel6.pol, sel6.ns};
            `ETS_OFF_S6_SEC: nxt_rdata = sel6.sec;
            `ETS_OFF_S6_PH: nxt_rdata = {29'h0, sel6.phase};
            `ETS_OFF_UNIT_IDX: nxt_rdata = {23'h0, idx_ff, 8'h0};
            `ETS_OFF_CTRL: nxt_rdata = {28'h0, fall_en_ff, rise_en_ff};
            `ETS_OFF_INT_STAT: nxt_rdata = {28'h0, int_stat_ff};
            `ETS_OFF_INT_MASK: nxt_rdata = {28'h0, int_mask_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    // read data register, zero when no read
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0;
        end else begin
            rdata <= bus.rd ? nxt_rdata : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [29:0] sel5_ns;
    logic [31:0] sel6_sec;
    logic rd_s5_ns;
    logic rd_s6_sec;
    logic rd_ph;
    logic [2:0] cap_phase;

    assign sel5_ns = sel5.ns;
    assign sel6_sec = sel6.sec;
    assign rd_s5_ns = bus.rd && bus.addr == `ETS_OFF_S5_NS;
    assign rd_s6_sec = bus.rd && bus.addr == `ETS_OFF_S6_SEC;
    assign rd_ph = bus.rd && (bus.addr == `ETS_OFF_S5_PH || bus.addr == `ETS_OFF_S6_PH);
    assign cap_phase = slot_q[0].phase;

    chk_unit_select: assert property (
        rd_s5_ns |=> rdata[29:0] == $past(sel5_ns))
        else $error("ns read does not follow selected unit");

    chk_edge_polarity: assert property (
        cap[0] |=> slot_q[0].pol == $past(rise[0]))
        else $error("fifth capture polarity wrong");

    chk_ns_capture: assert property (
        cap[1] |=> slot_q[1].ns == $past(ns_ff))
        else $error("captured nanoseconds wrong");

    chk_sec_read: assert property (
        rd_s6_sec |=> rdata == $past(sel6_sec))
        else $error("seconds read wrong");

    chk_phase_code: assert property (
        (cap[0] && sub_cnt_ff == 3'h4) |=> cap_phase == `ETS_PH_16NS)
        else $error("16 ns slot code wrong");

    chk_period_step: assert property (
        (sub_cnt_ff == 3'h7 && ns_ff < 30'd999999960) |=> ns_ff == $past(ns_ff) + 30'd40)
        else $error("ns not stepped by one period");

    chk_reserved_zero: assert property (
        rd_ph |=> rdata[31:3] == 29'h0 && rdata[2:0] <= 3'h4)
        else $error("reserved phase bits not zero");

    chk_irq_raise: assert property (
        (cap[2] && int_mask_ff[2]) |=> irq && int_stat_ff[2])
        else $error("masked-in capture did not raise irq");

    // capture contents, pointer view, status set, rearm clear and read data idle level
    chk_unit1_view: assert property (
        (rd_s5_ns && unit_sel) |=> rdata[29:0] == $past(slot_q[2].ns))
        else $error("unit one ns not shown when selected");

    chk_sixth_polarity: assert property (
        cap[3] |=> slot_q[3].pol == $past(rise[1]))
        else $error("sixth capture polarity wrong");

    chk_sec_capture: assert property (
        cap[0] |=> slot_q[0].sec == $past(sec_ff))
        else $error("captured seconds wrong");

    chk_sample_hold: assert property (
        !cap[0] |=> $stable(slot_q[0]))
        else $error("sample changed without a capture");

    chk_stat_set: assert property (
        cap[0] |=> int_stat_ff[0])
        else $error("capture did not set its status bit");

    chk_rd_idle: assert property (
        !bus.rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");

    chk_rearm_clear: assert property (
        (rearm[0] && !ev[0]) |=> cnt_ff[0] == 3'h0)
        else $error("rearm did not clear the edge count");

    cov_fifth: cover property (cap[0] ##[1:200] cap[1]);
    cov_phase16: cover property (cap[0] && slot_idx == 3'h2);
    cov_unit1: cover property (cap[3]);
    cov_rearm: cover property (rearm[0] && ev[0]);
    cov_irq: cover property ($rose(irq));
endmodule // ets_capture_top

// ---- test/ets_evt_src.sv ----
`timescale 1ns/1ps

// ------------------------------
// event pin source model
// ------------------------------
module ets_evt_src (
    // clock
    input wire logic clk,
    // event pins
    output logic [1:0] ts_in
);
    initial ts_in = 2'h0;

    // set one pin level, then hold it for hold clocks
    task automatic drive(input int u, input logic lvl, input int hold);
        ts_in[u] <= lvl;
        repeat (hold) @(posedge clk);
    endtask
endmodule // ets_evt_src

// ---- test/tb.sv ----
`timescale 1ns/1ps
`include "ets_defs.svh"

module tb;
    import ets_pkg::*;
    logic clk;
    logic rst;
    ets_bus_req_t bus;
    logic [31:0] rdata;
    logic [1:0] ts_in;
    logic irq;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int tmo = 0;
    int c5;
    int c6;
    logic [31:0] d;
    logic [31:0] keep5;

    ets_capture_top u_ets_capture_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .ts_in(ts_in), .irq(irq));
    ets_evt_src u_ets_evt_src (.clk(clk), .ts_in(ts_in));

    // ------------------------------
    // clock, cycle count, timeout
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (!rst) cyc <= cyc + 1;
        tmo <= tmo + 1;
        if (tmo == 6000) begin
            errors++;
            wrap_up();
        end
    end

    // ------------------------------
    // bus and compare tasks
    // ------------------------------
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] v);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        // idle edge so a following write never lowers and raises wr in one step
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [11:0] a, output logic [31:0] v);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        // data stands in the cycle after the strobe, taken at its closing edge
        @(posedge clk);
        v = rdata;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // phase code for a sub-cycle of the 40 ns reference period
    function automatic logic [2:0] ph_of(input int k);
        case (k)
            0, 1: ph_of = `ETS_PH_0NS;
            2, 3: ph_of = `ETS_PH_8NS;
            4: ph_of = `ETS_PH_16NS;
            5, 6: ph_of = `ETS_PH_24NS;
            default: ph_of = `ETS_PH_32NS;
        endcase
    endfunction
    // sample time must match the local time a few cycles after the pin edge
    task automatic chk_time(input string nm, input int c, input logic [29:0] ns,
        input logic [2:0] ph);
        int n;
        // two sync stages and the edge pulse, captured on the fourth edge
        n = c + 4;
        n_compared++;
        if (ns !== 30'(40 * (n / 8)) || ph !== ph_of(n % 8)) begin
            errors++;
            $display("CHECK FAILED %s expected cycle %0d seen %h/%h", nm, c, ns, ph);
        end
    endtask
    // read and check the three registers of one sample
    task automatic chk_sample(input logic [11:0] b, input logic pol, input int c);
        logic [31:0] ns;
        logic [31:0] ph;
        reg_rd(b, ns);
        chk32("edge bits", {30'h0, 1'b0, pol}, {30'h0, ns[31:30]});
        reg_rd(b + 12'h8, ph);
        chk32("phase reserved", 32'h0, {ph[31:3], 3'h0});
        chk_time("sample time", c, ns[29:0], ph[2:0]);
        reg_rd(b + 12'h4, d);
        chk32("seconds", 32'h0, d);
    endtask
    // pin edge on a unit, cycle noted
    task automatic pin(input int u, input logic lvl, input int hold, output int c);
        c = cyc;
        u_ets_evt_src.drive(u, lvl, hold);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        int c;
        bus = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            reg_rd(`ETS_OFF_S5_NS + 12'(i * 4), d);
            chk32("reset value", 32'h0, d);
        end
        $display("test reset values done");
        // six edges on unit 0, varying spacing to move the phase
        for (int i = 0; i < 6; i++) begin
            pin(0, (i % 2) == 0, 9 + i, c);
            if (i == 4) c5 = c;
            if (i == 5) c6 = c;
        end
        chk_sample(`ETS_OFF_S5_NS, 1'b1, c5);
        chk_sample(`ETS_OFF_S6_NS, 1'b0, c6);
        $display("test unit0 capture done");
        // status sticky, masked, then cleared
        reg_rd(`ETS_OFF_INT_STAT, d);
        chk32("int status", 32'h3, d);
        chk32("irq masked", 32'h0, {31'h0, irq});
        reg_wr(`ETS_OFF_INT_MASK, 32'hf);
        chk32("irq set", 32'h1, {31'h0, irq});
        reg_wr(`ETS_OFF_INT_STAT, 32'h3);
        chk32("irq clear", 32'h0, {31'h0, irq});
        reg_rd(`ETS_OFF_INT_STAT, d);
        chk32("int status clear", 32'h0, d);
        $display("test interrupt done");
        // seventh edge ignored, writes to samples ignored
        reg_rd(`ETS_OFF_S5_NS, keep5);
        pin(0, 1'b1, 10, c);
        reg_wr(`ETS_OFF_S5_NS, 32'hffffffff);
        reg_wr(`ETS_OFF_S6_PH, 32'hffffffff);
        reg_rd(`ETS_OFF_S5_NS, d);
        chk32("sample5 kept", keep5, d);
        chk_sample(`ETS_OFF_S6_NS, 1'b0, c6);
        $display("test read only done");
        // unit 1 with rising edges disabled: only falls are counted
        reg_wr(`ETS_OFF_CTRL, 32'hd);
        for (int i = 0; i < 12; i++) begin
            pin(1, (i % 2) == 0, 8 + i, c);
            if (i == 9) c5 = c;
            if (i == 11) c6 = c;
        end
        reg_wr(`ETS_OFF_UNIT_IDX, 32'h100);
        chk_sample(`ETS_OFF_S5_NS, 1'b0, c5);
        chk_sample(`ETS_OFF_S6_NS, 1'b0, c6);
        chk32("irq unit1", 32'h1, {31'h0, irq});
        reg_wr(`ETS_OFF_UNIT_IDX, 32'h0);
        reg_rd(`ETS_OFF_S5_NS, d);
        chk32("unit0 back", keep5, d);
        reg_rd(12'h5f0, d);
        chk32("unmapped", 32'h0, d);
        $display("test unit select done");
        // rearm unit 0: five more edges, the fifth (a fall) refills sample 5
        reg_wr(`ETS_OFF_CTRL, 32'h10f);
        for (int i = 0; i < 5; i++) begin
            pin(0, (i % 2) == 1, 9, c);
            if (i == 4) c5 = c;
        end
        chk_sample(`ETS_OFF_S5_NS, 1'b0, c5);
        $display("test rearm done");
        wrap_up();
    end
endmodule // tb
